/* logic/ckm_defs.svh */
// register offsets, field positions and reset values of the clock mux block
`ifndef CKM_DEFS_SVH
`define CKM_DEFS_SVH

// register indices; byte address is four times the index
`define CKM_IDX_OUT_ENABLES   8'h19
`define CKM_IDX_CLOCK_SELECT  8'h1A
`define CKM_IDX_FACTORY_MUX   8'h1B
`define CKM_IDX_FACTORY_CFG   8'h1C
`define CKM_IDX_SIDE_CONTROL  8'h1D

// output enable register fields
`define CKM_OE_RX_CLOCK       0
`define CKM_OE_ADAPTER        1
`define CKM_OE_TX_CLOCK       2
`define CKM_OE_INDICATOR      3
`define CKM_OE_RX_LINK        4
`define CKM_OE_DL_CLOCK       5
`define CKM_OE_MASK           8'h3F

// clock select register fields
`define CKM_SEL_TX_LINE_LSB   0
`define CKM_SEL_ADAPTER_LSB   2
`define CKM_SEL_TX_SYS_LSB    4
`define CKM_SEL_RX_SYS_LSB    6

// factory test field masks
`define CKM_FMUX_MASK         8'h3F
`define CKM_FCFG_MASK         8'h03

// side control register fields
`define CKM_SC_DL_DIR_IN      0
`define CKM_SC_SLIP_BYPASS    1
`define CKM_SC_JAT_ENABLE     2
`define CKM_SC_ADAPTER_EN     3
`define CKM_SC_NO_ADAPTER     4
`define CKM_SC_MASK           8'h1F

// reset values
`define CKM_RST_REG           8'h00
`define CKM_RST_SEL           2'h0

// glitch-free switch: quiet count loaded on a source change; output is held low this count plus three cycles before the new one
`define CKM_SWITCH_QUIET      4'h3

`endif

/* logic/ckm_pkg.sv */
// types shared by the clock mux block
package ckm_pkg;

  typedef enum logic [1:0] {
    CKM_SRC_OWN_PIN  = 2'h0,
    CKM_SRC_ALT_A    = 2'h1,
    CKM_SRC_ALT_B    = 2'h2,
    CKM_SRC_ALT_C    = 2'h3
  } ckm_src_t;

  typedef enum logic [1:0] {
    CKM_SW_RUN   = 2'h0,
    CKM_SW_QUIET = 2'h1,
    CKM_SW_LOAD  = 2'h3
  } ckm_sw_state_t;

  // one three-state output: level and enable
  typedef struct packed {
    logic val;
    logic oe;
  } ckm_pin_t;

  // every pin clock that enters the selectors, already synchronised
  typedef struct packed {
    logic rx_sys_clk;
    logic tx_sys_clk;
    logic adapter_ref_clk;
    logic tx_line_clk;
    logic recovered_rx_clock;
    logic adapter_clock_output;
  } ckm_clk_in_t;

endpackage

/* logic/ckm_glitchless_mux.sv */
// one four-way clock selector that parks low while changing source
`timescale 1ns/1ps
`default_nettype none
`include "ckm_defs.svh"

module ckm_glitchless_mux (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [3:0] src_i,
  output logic            clk_o,
  output logic [1:0]      active_sel_o
);

  ckm_pkg::ckm_sw_state_t state;
  logic [3:0]             quiet_cnt;

  // holds output low for a few cycles around a source change
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state        <= ckm_pkg::CKM_SW_RUN;
      quiet_cnt    <= 4'h0;
      active_sel_o <= `CKM_RST_SEL;
    end else begin
      case (state)
        ckm_pkg::CKM_SW_RUN: begin
          if (sel_i != active_sel_o) begin
            state     <= ckm_pkg::CKM_SW_QUIET;
            quiet_cnt <= `CKM_SWITCH_QUIET;
          end
        end
        ckm_pkg::CKM_SW_QUIET: begin
          if (quiet_cnt == 4'h0) begin
            state <= ckm_pkg::CKM_SW_LOAD;
          end else begin
            quiet_cnt <= quiet_cnt - 4'h1;
          end
        end
        ckm_pkg::CKM_SW_LOAD: begin
          active_sel_o <= sel_i;
          state        <= ckm_pkg::CKM_SW_RUN;
        end
        default: begin
          state <= ckm_pkg::CKM_SW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_o <= 1'b0;
    end else if (state != ckm_pkg::CKM_SW_RUN || sel_i != active_sel_o) begin
      clk_o <= 1'b0;
    end else begin
      clk_o <= src_i[active_sel_o];
    end
  end

endmodule
`default_nettype wire

/* logic/ckm_clock_mux.sv */
// register-steered clock source selection and output three-state control
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ckm_defs.svh"

// Operation
// - dl clock driven at 0, three-state at 1
// - pin input direction overrides dl enable
// - one bit gates both receive link outputs
// - one bit gates both indicator outputs
// - tx clock output enabled at 0
// - adapter output enabled at 0
// - no-adapter variant drives adapter pin low
// - recovered rx clock output enabled at 0
// - rx sysbus select bits 7:6 codes
// - rx sysbus pin ignored unless selected
// - tx sysbus select bits 5:4 codes
// - slip bypass uses no tx sysbus clock
// - adapter reference select bits 3:2 codes
// - reference used only while adapter enabled
// - tx line clock select bits 1:0
// - tx line clock must run line rate
// - jitter attenuator off routes clock out
// - tx clock pin ignored unless selected
module ckm_clock_mux #(
  parameter int ADDR_W = 8
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  // avalon-mm slave, word addressed by register index
  input  wire logic [ADDR_W-1:0]   avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  output logic [1:0]               avs_response_o,
  // clock pins from outside
  input  wire logic                rx_sys_clk_pin_i,
  input  wire logic                tx_sys_clk_pin_i,
  input  wire logic                adapter_ref_pin_i,
  input  wire logic                tx_line_clk_pin_i,
  // internal sources ahead of their buffers
  input  wire logic                recovered_rx_clock_i,
  input  wire logic                adapter_clock_output_i,
  input  wire logic                tx_jat_clock_i,
  input  wire logic                tx_datalink_clock_i,
  input  wire logic [1:0]          rx_link_data_i,
  input  wire logic [1:0]          indicator_data_i,
  // selected timebases
  output logic                     rx_sysbus_clk_o,
  output logic                     tx_sysbus_clk_o,
  output logic                     adapter_ref_clk_o,
  output logic                     tx_line_clk_o,
  // three-state outputs
  output ckm_pkg::ckm_pin_t        tx_datalink_clock_out_o,
  output ckm_pkg::ckm_pin_t [1:0]  rx_link_out_o,
  output ckm_pkg::ckm_pin_t [1:0]  indicator_out_o,
  output ckm_pkg::ckm_pin_t        tx_clock_out_pin_o,
  output ckm_pkg::ckm_pin_t        adapter_clock_out_o,
  output ckm_pkg::ckm_pin_t        recovered_rx_clock_out_o
);

  logic [7:0] output_buffer_enables;
  logic [7:0] clock_source_select;
  logic [7:0] factory_test_mux;
  logic [7:0] factory_test_config;
  logic [7:0] side_control;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_q;
  logic       req_done;
  ckm_pkg::ckm_clk_in_t clk_in;

  // ---------------- avalon-mm slave ----------------
  // one wait cycle: waitrequest drops on the second cycle of a request
  wire logic req = avs_read_i | avs_write_i;
  wire logic [7:0] idx = 8'(avs_address_i);
  wire logic wr_now = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_done <= 1'b0;
    end else begin
      req_done <= req & avs_waitrequest_o & ~req_done;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o & ~req_done);
    end
  end

  // register writes; only byte lane 0 holds data
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_buffer_enables <= `CKM_RST_REG;
      clock_source_select   <= `CKM_RST_REG;
      factory_test_mux      <= `CKM_RST_REG;
      factory_test_config   <= `CKM_RST_REG;
      side_control          <= `CKM_RST_REG;
    end else if (wr_now) begin
      if (idx == `CKM_IDX_OUT_ENABLES) begin
        output_buffer_enables <= avs_writedata_i[7:0] & `CKM_OE_MASK;
      end else if (idx == `CKM_IDX_CLOCK_SELECT) begin
        clock_source_select <= avs_writedata_i[7:0];
      end else if (idx == `CKM_IDX_FACTORY_MUX) begin
        // stored only; no function behind it
        factory_test_mux <= avs_writedata_i[7:0] & `CKM_FMUX_MASK;
      end else if (idx == `CKM_IDX_FACTORY_CFG) begin
        factory_test_config <= avs_writedata_i[7:0] & `CKM_FCFG_MASK;
      end else if (idx == `CKM_IDX_SIDE_CONTROL) begin
        side_control <= avs_writedata_i[7:0] & `CKM_SC_MASK;
      end
    end
  end

  // read data and response, valid while waitrequest is low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else if (req & avs_waitrequest_o & ~req_done) begin
      avs_response_o <= 2'h0;
      if (idx == `CKM_IDX_OUT_ENABLES) begin
        avs_readdata_o <= {24'h000000, output_buffer_enables};
      end else if (idx == `CKM_IDX_CLOCK_SELECT) begin
        avs_readdata_o <= {24'h000000, clock_source_select};
      end else if (idx == `CKM_IDX_FACTORY_MUX) begin
        avs_readdata_o <= {24'h000000, factory_test_mux};
      end else if (idx == `CKM_IDX_FACTORY_CFG) begin
        avs_readdata_o <= {24'h000000, factory_test_config};
      end else if (idx == `CKM_IDX_SIDE_CONTROL) begin
        avs_readdata_o <= {24'h000000, side_control};
      end else begin
        avs_readdata_o <= 32'h0000_0000;
        avs_response_o <= 2'h2;
      end
    end
  end

  // ---------------- pin synchronisers ----------------
  // three stages; a change is taken once stages two and three agree
  wire logic [5:0] raw_pins = {adapter_clock_output_i, recovered_rx_clock_i,
                               tx_line_clk_pin_i, adapter_ref_pin_i,
                               tx_sys_clk_pin_i, rx_sys_clk_pin_i};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_s3 <= 6'h00;
    end else begin
      pin_s1 <= raw_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_q[g] <= 1'b0;
        end else if (pin_s2[g] == pin_s3[g]) begin
          pin_q[g] <= pin_s3[g];
        end
      end
    end
  endgenerate

  // fields named one by one, so the struct's bit order cannot swap pins
  assign clk_in = '{
    rx_sys_clk:           pin_q[0],
    tx_sys_clk:           pin_q[1],
    adapter_ref_clk:      pin_q[2],
    tx_line_clk:          pin_q[3],
    recovered_rx_clock:   pin_q[4],
    adapter_clock_output: pin_q[5]
  };

  // ---------------- clock selectors ----------------
  wire logic [1:0] rx_sys_sel   = clock_source_select[`CKM_SEL_RX_SYS_LSB +: 2];
  wire logic [1:0] tx_sys_sel   = clock_source_select[`CKM_SEL_TX_SYS_LSB +: 2];
  wire logic [1:0] adapter_sel  = clock_source_select[`CKM_SEL_ADAPTER_LSB +: 2];
  wire logic [1:0] tx_line_sel  = clock_source_select[`CKM_SEL_TX_LINE_LSB +: 2];
  wire logic       slip_bypass  = side_control[`CKM_SC_SLIP_BYPASS];
  wire logic       adapter_en   = side_control[`CKM_SC_ADAPTER_EN];
  logic rx_sys_raw;
  logic tx_sys_raw;
  logic adapter_raw;
  logic tx_line_raw;

  // own pin only reaches the mux on code 00
  ckm_glitchless_mux u_rx_sys (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .sel_i        (rx_sys_sel),
    .src_i        ({clk_in.adapter_clock_output, clk_in.adapter_ref_clk,
                    clk_in.tx_sys_clk, clk_in.rx_sys_clk}),
    .clk_o        (rx_sys_raw),
    .active_sel_o ()
  );

  ckm_glitchless_mux u_tx_sys (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .sel_i        (tx_sys_sel),
    .src_i        ({clk_in.adapter_clock_output, clk_in.adapter_ref_clk,
                    clk_in.rx_sys_clk, clk_in.tx_sys_clk}),
    .clk_o        (tx_sys_raw),
    .active_sel_o ()
  );

  ckm_glitchless_mux u_adapter (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .sel_i        (adapter_sel),
    .src_i        ({clk_in.tx_line_clk, clk_in.tx_sys_clk,
                    clk_in.recovered_rx_clock, clk_in.adapter_ref_clk}),
    .clk_o        (adapter_raw),
    .active_sel_o ()
  );

  // line-rate source is the user's choice
  ckm_glitchless_mux u_tx_line (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .sel_i        (tx_line_sel),
    .src_i        ({clk_in.adapter_clock_output, clk_in.rx_sys_clk,
                    clk_in.recovered_rx_clock, clk_in.tx_line_clk}),
    .clk_o        (tx_line_raw),
    .active_sel_o ()
  );

  // each timebase output has its own register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sysbus_clk_o <= 1'b0;
    end else begin
      rx_sysbus_clk_o <= rx_sys_raw;
    end
  end

  // a bypassed slip buffer takes no tx bus clock at all
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sysbus_clk_o <= 1'b0;
    end else begin
      tx_sysbus_clk_o <= tx_sys_raw & ~slip_bypass;
    end
  end

  // the reference only counts while the adapter runs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adapter_ref_clk_o <= 1'b0;
    end else begin
      adapter_ref_clk_o <= adapter_raw & adapter_en;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_line_clk_o <= 1'b0;
    end else begin
      tx_line_clk_o <= tx_line_raw;
    end
  end

  // ---------------- output buffers ----------------
  wire logic [5:0] oe_n = output_buffer_enables[5:0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_datalink_clock_out_o <= '0;
    end else begin
      tx_datalink_clock_out_o.val <= tx_datalink_clock_i;
      // input direction wins over the enable
      tx_datalink_clock_out_o.oe  <= ~oe_n[`CKM_OE_DL_CLOCK] &
                                     ~side_control[`CKM_SC_DL_DIR_IN];
    end
  end

  generate
    for (g = 0; g < 2; g++) begin : g_pair
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          rx_link_out_o[g]   <= '0;
          indicator_out_o[g] <= '0;
        end else begin
          rx_link_out_o[g].val   <= rx_link_data_i[g];
          rx_link_out_o[g].oe    <= ~oe_n[`CKM_OE_RX_LINK];
          indicator_out_o[g].val <= indicator_data_i[g];
          indicator_out_o[g].oe  <= ~oe_n[`CKM_OE_INDICATOR];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_clock_out_pin_o <= '0;
    end else begin
      // jitter attenuator off: selected line clock goes out
      tx_clock_out_pin_o.val <= side_control[`CKM_SC_JAT_ENABLE] ?
                                tx_jat_clock_i : tx_line_raw;
      tx_clock_out_pin_o.oe  <= ~oe_n[`CKM_OE_TX_CLOCK];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adapter_clock_out_o <= '0;
    end else begin
      // variant without adapter holds the pin low
      adapter_clock_out_o.val <= side_control[`CKM_SC_NO_ADAPTER] ? 1'b0 :
                                 clk_in.adapter_clock_output;
      adapter_clock_out_o.oe  <= ~oe_n[`CKM_OE_ADAPTER];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recovered_rx_clock_out_o <= '0;
    end else begin
      recovered_rx_clock_out_o.val <= clk_in.recovered_rx_clock;
      recovered_rx_clock_out_o.oe  <= ~oe_n[`CKM_OE_RX_CLOCK];
    end
  end

endmodule
`default_nettype wire

/* bench/ckm_mux_chk_asserts.sv */
// port checker of the clock mux block
`timescale 1ns/1ps
`default_nettype none
`include "ckm_defs.svh"
module ckm_mux_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  input wire logic [ADDR_W-1:0]       avs_address_i,
  input wire logic                    avs_read_i,
  input wire logic                    avs_write_i,
  input wire logic [31:0]             avs_writedata_i,
  input wire logic [3:0]              avs_byteenable_i,
  input wire logic                    avs_waitrequest_o,
  input wire logic                    tx_line_clk_o,
  input wire ckm_pkg::ckm_pin_t       tx_datalink_clock_out_o,
  input wire ckm_pkg::ckm_pin_t [1:0] rx_link_out_o,
  input wire ckm_pkg::ckm_pin_t [1:0] indicator_out_o,
  input wire ckm_pkg::ckm_pin_t       tx_clock_out_pin_o,
  input wire ckm_pkg::ckm_pin_t       adapter_clock_out_o,
  input wire ckm_pkg::ckm_pin_t       recovered_rx_clock_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] oe;
  logic [7:0] sc;
  logic [1:0] sel;
  logic [1:0] quiet;
  logic       wdone;
  logic       ok;
  assign wdone = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  // pins are judged only two cycles after the last register write
  assign ok = quiet[1];
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe <= 8'h00;
      sc <= 8'h00;
      sel <= 2'h0;
      quiet <= 2'h0;
    end else begin
      if (wdone && avs_address_i == ADDR_W'(`CKM_IDX_OUT_ENABLES)) begin
        oe <= avs_writedata_i[7:0];
      end
      if (wdone && avs_address_i == ADDR_W'(`CKM_IDX_SIDE_CONTROL)) begin
        sc <= avs_writedata_i[7:0];
      end
      if (wdone && avs_address_i == ADDR_W'(`CKM_IDX_CLOCK_SELECT)) begin
        sel <= avs_writedata_i[1:0];
      end
      quiet <= wdone ? 2'h0 : (quiet[1] ? quiet : quiet + 2'h1);
    end
  end
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_line_sw;
    wdone && avs_address_i == ADDR_W'(`CKM_IDX_CLOCK_SELECT) && avs_writedata_i[1:0] != sel;
  endsequence
  sequence s_parked;
    !tx_line_clk_o [*3];
  endsequence
  property p_answer;
    s_taken |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered");
  property p_switch;
    s_line_sw |-> ##[1:5] s_parked;
  endproperty
  a_switch: assert property (p_switch) else $error("line clock not parked low");
  property p_dl;
    ok |-> tx_datalink_clock_out_o.oe == !(oe[5] || sc[0]);
  endproperty
  a_dl: assert property (p_dl) else $error("dl clock enable wrong");
  property p_rxl;
    ok |-> rx_link_out_o[0].oe == !oe[4] && rx_link_out_o[1].oe == !oe[4];
  endproperty
  a_rxl: assert property (p_rxl) else $error("rx link enables wrong");
  property p_ind;
    ok |-> indicator_out_o[0].oe == !oe[3] && indicator_out_o[1].oe == !oe[3];
  endproperty
  a_ind: assert property (p_ind) else $error("indicator enables wrong");
  property p_txck;
    ok |-> tx_clock_out_pin_o.oe == !oe[2];
  endproperty
  a_txck: assert property (p_txck) else $error("tx clock enable wrong");
  property p_adp;
    ok |-> adapter_clock_out_o.oe == !oe[1];
  endproperty
  a_adp: assert property (p_adp) else $error("adapter enable wrong");
  property p_adlow;
    ok && sc[4] && !oe[1] |-> !adapter_clock_out_o.val;
  endproperty
  a_adlow: assert property (p_adlow) else $error("adapter pin not low");
  property p_rck;
    ok |-> recovered_rx_clock_out_o.oe == !oe[0];
  endproperty
  a_rck: assert property (p_rck) else $error("rx clock enable wrong");
endmodule
bind ckm_clock_mux ckm_mux_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* bench/ckm_clk_partner.sv */
// model of the clock pins and internal clock sources feeding the mux
`timescale 1ns/1ps
`default_nettype none
module ckm_clk_partner (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [5:0] level_i,
  output logic [5:0]      src_o
);
  logic [7:0] div;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end
  // each source but the rx and tx sysbus pins keeps a steady rate, as line-rate clocks do; those two mix two divider taps
  // the bus clock runs on even while a bypassed slip buffer must ignore it
  assign src_o = run_i ? {div[2], div[3], div[4], div[5], div[3] ^ div[6], div[2] ^ div[7]}
                       : level_i;
endmodule
`default_nettype wire

/* bench/ckm_clock_mux_bench.sv */
// self-checking bench of the clock mux block
`timescale 1ns/1ps
`default_nettype none
module ckm_clock_mux_bench;
  logic                    sys_clk_i, rst_n_i, rd, wr, wq, run, jat, dlc;
  logic                    rsc, tsc, arc, tlc;
  logic [7:0]              adr, oev;
  logic [3:0]              be, clkv;
  logic [31:0]             wd, rdat, rnd;
  logic [1:0]              rsp, rxl, ind;
  logic [5:0]              lvl, src;
  logic [4:0]              prv, vals;
  ckm_pkg::ckm_pin_t       dlo, txo, ado, rco;
  ckm_pkg::ckm_pin_t [1:0] rlo, ino;
  logic [33:0]             expq[$];
  int                      errors, total_checks, cyc;
  int                      map[4][4] = '{'{0, 1, 2, 5}, '{1, 0, 2, 5},
                                         '{2, 4, 1, 3}, '{3, 4, 0, 5}};
  assign oev = {dlo.oe, rlo[1].oe, rlo[0].oe, ino[1].oe, ino[0].oe, txo.oe, ado.oe, rco.oe};
  assign clkv = {tlc, arc, tsc, rsc};
  assign vals = {rlo[1].val, rlo[0].val, ino[1].val, ino[0].val, dlo.val};
  ckm_clock_mux u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .avs_response_o(rsp),
    .rx_sys_clk_pin_i(src[0]), .tx_sys_clk_pin_i(src[1]), .adapter_ref_pin_i(src[2]),
    .tx_line_clk_pin_i(src[3]), .recovered_rx_clock_i(src[4]), .adapter_clock_output_i(src[5]),
    .tx_jat_clock_i(jat), .tx_datalink_clock_i(dlc), .rx_link_data_i(rxl),
    .indicator_data_i(ind), .rx_sysbus_clk_o(rsc), .tx_sysbus_clk_o(tsc),
    .adapter_ref_clk_o(arc), .tx_line_clk_o(tlc), .tx_datalink_clock_out_o(dlo),
    .rx_link_out_o(rlo), .indicator_out_o(ino), .tx_clock_out_pin_o(txo),
    .adapter_clock_out_o(ado), .recovered_rx_clock_out_o(rco));
  ckm_clk_partner u_src (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(run),
    .level_i(lvl), .src_o(src));
  always #25 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [33:0] e);
    if (!w) expq.push_back(e);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    do @(posedge sys_clk_i); while (wq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 34'h0);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [33:0] e);
    bus(1'b0, a, 8'h00, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  always @(posedge sys_clk_i) begin
    rnd <= xs(rnd);
    rxl <= rnd[1:0];
    ind <= rnd[3:2];
    dlc <= rnd[4];
  end
  // read answers are matched against the oldest noted expectation
  always @(posedge sys_clk_i) begin
    if (rd && wq === 1'b0) begin
      check({rsp, rdat}, expq.pop_front());
    end
    // data outputs carry last cycle's internal sources
    prv <= {rxl, ind, dlc};
    if (cyc > 4) check({29'h0, vals}, {29'h0, prv});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] d;
    logic [7:0] ra[3];
    logic [7:0] mk[3];
    ra = '{8'h19, 8'h1A, 8'h1D};
    mk = '{8'h3F, 8'hFF, 8'h1F};
    sys_clk_i = 1'b0;
    rst_n_i = 1'b0;
    {rd, wr, run, jat, dlc, rxl, ind, adr, wd, lvl} = '0;
    be = 4'hF;
    rnd = 32'h4A13;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    wt(2);
    rst_n_i <= 1'b1;
    // factory fields are only read back, never set
    for (int i = 8'h19; i <= 8'h1D; i++) rreg(8'(i), 34'h0);
    rreg(8'h20, {2'h2, 32'h0});
    for (int k = 0; k < 12; k++) begin
      d = rnd[7:0];
      wreg(ra[k % 3], d);
      rreg(ra[k % 3], {26'h0, d & mk[k % 3]});
    end
    wreg(8'h19, 8'h2A);
    be <= 4'hE;
    wreg(8'h19, 8'h15);
    be <= 4'hF;
    rreg(8'h19, {26'h0, 8'h2A});
    wreg(8'h1D, 8'h11);
    wreg(8'h19, 8'h00);
    wt(3);
    check({26'h0, oev}, {26'h0, 8'h7F});
    check({33'h0, ado.val}, 34'h0);
    wreg(8'h1D, 8'h00);
    wt(3);
    check({26'h0, oev}, {26'h0, 8'hFF});
    wreg(8'h19, 8'h3F);
    wt(3);
    check({26'h0, oev}, 34'h0);
    wreg(8'h1D, 8'h08);
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        for (int p = 0; p < 2; p++) begin
          lvl <= p ? ~(6'h1 << map[s][c]) : 6'h1 << map[s][c];
          wreg(8'h1A, 8'(c << (6 - 2 * s)));
          wt(20);
          check(34'(clkv[s]), 34'(p == 0));
          if (s == 3) check({33'h0, txo.val}, {33'h0, p == 0});
        end
      end
    end
    lvl <= 6'h00;
    jat <= 1'b1;
    wreg(8'h1D, 8'h0C);
    wt(20);
    check({33'h0, txo.val}, 34'h1);
    wreg(8'h1A, 8'h00);
    lvl <= 6'h02;
    wreg(8'h1D, 8'h0A);
    wt(20);
    check({33'h0, tsc}, 34'h0);
    lvl <= 6'h04;
    wreg(8'h1D, 8'h00);
    wt(20);
    check({33'h0, arc}, 34'h0);
    run <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wreg(8'h1A, {4{2'(c)}});
      wt(30);
    end
    stop_test();
  end
endmodule
`default_nettype wire
